// File: flash_prot_pkg.sv
// Operation
// RQ1: Processor misbehaviour during program/erase sets error
// RQ2: Error keeps registers, aborts program/erase mode
// RQ3: Error protection ignores program/erase re-entry
// RQ4: Error protection still allows verify bits
// RQ5: Flash read during operation sets error
// RQ6: Non-reset exception during operation sets error
// RQ7: Sleep during operation sets error
// RQ8: Foreign bus master during operation sets error
// RQ9: Overlay enable protects all blocks
// RQ10: Software writes 1,0,0,1 to overlay block one
// RQ11: Clearing overlay enable releases the overlay
// RQ12: RAM window reachable at both addresses
// RQ13: Clear software write enable protects all
// RQ14: Zero erase selects erase-protect all blocks
// RQ15: Error flag persists until reset
package flash_prot_pkg;
  localparam logic [11:0] ADDR_CTRL_ONE = 12'h000;
  localparam logic [11:0] ADDR_CTRL_TWO = 12'h004;
  localparam logic [11:0] ADDR_EBS_ONE = 12'h008;
  localparam logic [11:0] ADDR_EBS_TWO = 12'h00C;
  localparam logic [11:0] ADDR_OVL_CTRL = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h014;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
  // Control one fields
  localparam int BIT_PROG = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_PVER = 2;
  localparam int BIT_EVER = 3;
  localparam int BIT_WR_ENABLE = 6;
  // Control two field
  localparam int BIT_ERR_FLAG = 7;
  // Overlay control fields
  localparam int BIT_OVL_EN = 3;
  localparam int OVL_SEL_LSB = 0;
  // Interrupt status fields
  localparam int IRQ_ERR = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_W = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] EBS_RESET = 8'h00;
  localparam logic [3:0] OVL_RESET = 4'h0;
  // Overlay RAM window and flash block size
  localparam logic [23:0] RAM_WIN_BASE = 24'hFFDC00;
  localparam logic [23:0] RAM_WIN_LAST = 24'hFFEBFF;
  localparam logic [23:0] BLOCK_SIZE = 24'h001000;
  localparam int BLOCK_AW = 12;
endpackage

// File: flash_error_detect.sv
module flash_error_detect
  import flash_prot_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic op_active,
  input wire logic flash_read,
  input wire logic exception_taken,
  input wire logic reset_exception,
  input wire logic sleep_exec,
  input wire logic foreign_master,
  output logic error_flag,
  output logic error_pulse
);
  logic cause;
  always_comb begin
    // RQ5 flash read
    cause = flash_read;
    // RQ6 non-reset exception
    if (exception_taken && !reset_exception) begin
      cause = 1'b1;
    end
    // RQ7 sleep executed
    if (sleep_exec) begin
      cause = 1'b1;
    end
    // RQ8 foreign bus master
    if (foreign_master) begin
      cause = 1'b1;
    end
    cause = cause && op_active;
  end

  // RQ1 sticky error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      error_flag <= 1'b0;
      error_pulse <= 1'b0;
    end else begin
      error_pulse <= cause && !error_flag;
      // RQ15 only reset clears
      if (cause) begin
        error_flag <= 1'b1;
      end
    end
  end
endmodule

// File: flash_overlay_map.sv
module flash_overlay_map
  import flash_prot_pkg::*;
(
  input wire logic [3:0] overlay_ctrl,
  input wire logic [23:0] addr,
  output logic ram_hit,
  output logic [23:0] ram_addr
);
  logic [23:0] blk_base;
  always_comb begin
    blk_base = {9'h000, overlay_ctrl[2:0], 12'h000};
    ram_hit = 1'b0;
    ram_addr = addr;
    // RQ12 dual window
    if (addr >= RAM_WIN_BASE && addr <= RAM_WIN_LAST) begin
      ram_hit = 1'b1;
    end
    // RQ11 overlay only while enabled
    if (overlay_ctrl[BIT_OVL_EN] && addr[23:BLOCK_AW] == blk_base[23:BLOCK_AW]) begin
      ram_hit = 1'b1;
      ram_addr = RAM_WIN_BASE + {12'h000, addr[BLOCK_AW-1:0]};
    end
  end
endmodule

// File: flash_protect.sv
module flash_protect
  import flash_prot_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic flash_read,
  input wire logic exception_taken,
  input wire logic reset_exception,
  input wire logic sleep_exec,
  input wire logic foreign_master,
  input wire logic [23:0] cpu_addr,
  output logic ram_select,
  output logic [23:0] ram_addr,
  output logic program_active,
  output logic erase_active,
  output logic verify_program,
  output logic verify_erase,
  output logic [15:0] erase_enable,
  output logic irq
);
  logic [7:0] flash_control_reg_one;
  logic [7:0] erase_block_select_one;
  logic [7:0] erase_block_select_two;
  logic [3:0] ram_overlay_control;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic flash_error_flag;
  logic err_pulse;
  logic op_active;
  logic wr_en;
  logic prot_all;
  logic map_hit;
  logic [23:0] map_addr;
  logic [7:0] next_ctrl;
  logic [IRQ_W-1:0] irq_events;
  logic abort_now;
  logic wr_prot;

  assign wr_en = psel && penable && pwrite;
  assign op_active = flash_control_reg_one[BIT_PROG] || flash_control_reg_one[BIT_ERASE];
  // RQ9 RQ13 global protection
  assign prot_all = !flash_control_reg_one[BIT_WR_ENABLE] || ram_overlay_control[BIT_OVL_EN];
  // RQ13 write clearing enable
  assign wr_prot = prot_all || !pwdata[BIT_WR_ENABLE];
  // RQ2 abort in detect cycle
  assign abort_now = op_active && (flash_read || sleep_exec || foreign_master ||
                                   (exception_taken && !reset_exception));

  flash_error_detect u_det (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .op_active(op_active),
    .flash_read(flash_read),
    .exception_taken(exception_taken),
    .reset_exception(reset_exception),
    .sleep_exec(sleep_exec),
    .foreign_master(foreign_master),
    .error_flag(flash_error_flag),
    .error_pulse(err_pulse)
  );

  flash_overlay_map u_map (
    .overlay_ctrl(ram_overlay_control),
    .addr(cpu_addr),
    .ram_hit(map_hit),
    .ram_addr(map_addr)
  );

  always_comb begin
    next_ctrl = flash_control_reg_one;
    if (wr_en && paddr == ADDR_CTRL_ONE) begin
      next_ctrl = pwdata[7:0];
      // RQ3 block re-entry
      if (flash_error_flag || wr_prot) begin
        next_ctrl[BIT_PROG] = flash_control_reg_one[BIT_PROG] & ~wr_prot;
        next_ctrl[BIT_ERASE] = flash_control_reg_one[BIT_ERASE] & ~wr_prot;
        if (!pwdata[BIT_PROG]) next_ctrl[BIT_PROG] = 1'b0;
        if (!pwdata[BIT_ERASE]) next_ctrl[BIT_ERASE] = 1'b0;
      end
      // RQ4 verify still allowed
      next_ctrl[BIT_PVER] = pwdata[BIT_PVER];
      next_ctrl[BIT_EVER] = pwdata[BIT_EVER];
    end
    // RQ2 abort on error
    if (abort_now || flash_error_flag) begin
      next_ctrl[BIT_PROG] = 1'b0;
      next_ctrl[BIT_ERASE] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flash_control_reg_one <= CTRL_RESET;
    end else begin
      flash_control_reg_one <= next_ctrl;
    end
  end

  // RQ2 selects retained
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      erase_block_select_one <= EBS_RESET;
      erase_block_select_two <= EBS_RESET;
      ram_overlay_control <= OVL_RESET;
      irq_mask <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_EBS_ONE: erase_block_select_one <= pwdata[7:0];
        ADDR_EBS_TWO: erase_block_select_two <= pwdata[7:0];
        // RQ10 RQ11 overlay control
        ADDR_OVL_CTRL: ram_overlay_control <= pwdata[3:0];
        ADDR_IRQ_MASK: irq_mask <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Abort is flagged at detection, error one cycle later
  assign irq_events = {abort_now, err_pulse};

  // Set wins over write-one-to-clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else begin
      if (wr_en && paddr == ADDR_IRQ_STATUS) begin
        irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        case (paddr)
          ADDR_CTRL_ONE: prdata <= {24'h0, flash_control_reg_one};
          ADDR_CTRL_TWO: prdata <= {24'h0, flash_error_flag, 7'h00};
          ADDR_EBS_ONE: prdata <= {24'h0, erase_block_select_one};
          ADDR_EBS_TWO: prdata <= {24'h0, erase_block_select_two};
          ADDR_OVL_CTRL: prdata <= {28'h0, ram_overlay_control};
          ADDR_IRQ_STATUS: prdata <= {30'h0, irq_status};
          ADDR_IRQ_MASK: prdata <= {30'h0, irq_mask};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      program_active <= 1'b0;
      erase_active <= 1'b0;
      verify_program <= 1'b0;
      verify_erase <= 1'b0;
      erase_enable <= '0;
      irq <= 1'b0;
      ram_select <= 1'b0;
      ram_addr <= '0;
    end else begin
      program_active <= next_ctrl[BIT_PROG];
      erase_active <= next_ctrl[BIT_ERASE];
      verify_program <= next_ctrl[BIT_PVER];
      verify_erase <= next_ctrl[BIT_EVER];
      // RQ14 per-block erase protection
      erase_enable <= prot_all ? 16'h0000 : {erase_block_select_two, erase_block_select_one};
      irq <= |(irq_status & irq_mask);
      ram_select <= map_hit;
      ram_addr <= map_addr;
    end
  end
endmodule

// File: flash_protect_chk.sv
module flash_protect_chk
  import flash_prot_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flash_read,
  input wire logic exception_taken,
  input wire logic reset_exception,
  input wire logic sleep_exec,
  input wire logic foreign_master,
  input wire logic [23:0] cpu_addr,
  input wire logic ram_select,
  input wire logic [23:0] ram_addr,
  input wire logic program_active,
  input wire logic erase_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic fault;
  logic wr_one;
  logic in_win;
  assign fault = flash_read | sleep_exec | foreign_master | (exception_taken & !reset_exception);
  assign wr_one = psel & penable & pwrite & (paddr == ADDR_CTRL_ONE);
  assign in_win = (cpu_addr >= RAM_WIN_BASE) && (cpu_addr <= RAM_WIN_LAST);
  chk_abort_fault:
    assert property ((program_active | erase_active) && fault |=> !program_active && !erase_active) else $error("no abort");
  chk_prog_by_write:
    assert property ($rose(program_active) |-> $past(wr_one && pwdata[BIT_PROG])) else $error("prog rose alone");
  chk_erase_by_write:
    assert property ($rose(erase_active) |-> $past(wr_one && pwdata[BIT_ERASE])) else $error("erase rose alone");
  chk_ready_next:
    assert property (psel && !penable |=> pready) else $error("late ready");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("long ready");
  chk_err_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  chk_ram_hit:
    assert property (in_win |=> ram_select) else $error("window miss");
  chk_ram_addr:
    assert property (in_win |=> ram_addr == $past(cpu_addr)) else $error("window address");
  cover property (fault && program_active);
  cover property (pslverr);
  cover property ($rose(ram_select));
endmodule

bind flash_protect flash_protect_chk flash_protect_chk_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .flash_read, .exception_taken, .reset_exception, .sleep_exec,
  .foreign_master, .cpu_addr, .ram_select, .ram_addr, .program_active, .erase_active);

// File: cpu_event_model.sv
module cpu_event_model (
  input wire logic clk_sys,
  input wire logic fire,
  input wire logic [2:0] kind,
  output logic flash_read,
  output logic exception_taken,
  output logic reset_exception,
  output logic sleep_exec,
  output logic foreign_master
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fire_q = 1'b0;
  logic [2:0] kind_q = 3'h0;
  always @(posedge clk_sys) begin
    fire_q <= fire;
    kind_q <= kind;
  end
  assign flash_read = fire_q && kind_q == 3'h0;
  assign exception_taken = fire_q && (kind_q == 3'h1 || kind_q == 3'h4);
  assign reset_exception = fire_q && kind_q == 3'h4;
  assign sleep_exec = fire_q && kind_q == 3'h2;
  assign foreign_master = fire_q && kind_q == 3'h3;
endmodule

// File: testbench.sv
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_prot_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [23:0] cpu_addr = 24'h0, ram_addr, off;
  logic [15:0] erase_enable;
  logic [7:0] sel;
  logic [2:0] kind = 3'h0;
  logic pready, pslverr, flash_read, exception_taken, reset_exception, sleep_exec, foreign_master;
  logic ram_select, program_active, erase_active, verify_program, verify_erase, irq, err, i0;
  int n_fail = 0, num_checks = 0;
  flash_protect flash_protect_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .flash_read, .exception_taken, .reset_exception, .sleep_exec, .foreign_master,
    .cpu_addr, .ram_select, .ram_addr, .program_active, .erase_active, .verify_program, .verify_erase,
    .erase_enable, .irq);
  cpu_event_model cpu_event_model_inst (.clk_sys, .fire, .kind, .flash_read, .exception_taken,
    .reset_exception, .sleep_exec, .foreign_master);
  initial forever #2 clk_sys = ~clk_sys;
  function automatic logic [23:0] exp_ram(input logic [23:0] a);
    return RAM_WIN_BASE + (a - BLOCK_SIZE);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(28));
    do_reset();
    apb(1'b0, ADDR_CTRL_ONE, 32'h0);
    `CHK("ctrl_rst", 32'h0, rd)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 1'b1, err)
    for (int k = 0; k < 5; k++) begin
      do_reset();
      sel = 8'($urandom_range(1, 255));
      apb(1'b1, ADDR_EBS_ONE, {24'h0, sel});
      apb(1'b1, ADDR_CTRL_ONE, 32'h40);
      apb(1'b1, ADDR_CTRL_ONE, 32'h40 | (32'h1 << (k % 2)));
      `CHK("erase_en", {8'h00, sel}, erase_enable)
      fire <= 1'b1;
      kind <= 3'(k);
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK("active", 1'(k == 4), program_active | erase_active)
      apb(1'b0, ADDR_CTRL_TWO, 32'h0);
      `CHK("err_flag", 1'(k != 4), rd[BIT_ERR_FLAG])
      apb(1'b0, ADDR_EBS_ONE, 32'h0);
      `CHK("sel_kept", sel, rd[7:0])
      if (k < 4) begin
        apb(1'b1, ADDR_CTRL_ONE, 32'h43);
        `CHK("reenter", 1'b0, program_active | erase_active)
        apb(1'b1, ADDR_CTRL_ONE, 32'h4C);
        `CHK("verify", 2'b11, {verify_program, verify_erase})
        apb(1'b1, ADDR_CTRL_TWO, 32'h0);
        apb(1'b0, ADDR_CTRL_TWO, 32'h0);
        `CHK("err_sticky", 1'b1, rd[BIT_ERR_FLAG])
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        @(posedge clk_sys);
        i0 = irq;
        apb(1'b1, ADDR_IRQ_MASK, 32'hFF);
        @(posedge clk_sys);
        `CHK("irq_mask", 1'b1, i0 ^ irq)
        apb(1'b1, ADDR_IRQ_STATUS, 32'h3);
        @(posedge clk_sys);
        `CHK("irq_clear", 1'b0, irq)
      end
    end
    do_reset();
    apb(1'b1, ADDR_CTRL_ONE, 32'h40);
    apb(1'b1, ADDR_OVL_CTRL, 32'h9);
    off = BLOCK_SIZE + 24'($urandom_range(0, 4095));
    cpu_addr <= off;
    repeat (2) @(posedge clk_sys);
    `CHK("ovl_hit", 1'b1, ram_select)
    `CHK("ovl_addr", exp_ram(off), ram_addr)
    apb(1'b1, ADDR_CTRL_ONE, 32'h41);
    `CHK("ovl_prot", 1'b0, program_active)
    apb(1'b1, ADDR_OVL_CTRL, 32'h1);
    @(posedge clk_sys);
    `CHK("ovl_off", 1'b0, ram_select)
    cpu_addr <= RAM_WIN_BASE + 24'($urandom_range(0, 4095));
    repeat (2) @(posedge clk_sys);
    `CHK("win_hit", 1'b1, ram_select)
    `CHK("win_addr", cpu_addr, ram_addr)
    apb(1'b1, ADDR_CTRL_ONE, 32'h01);
    `CHK("swe_prot", 1'b0, program_active)
    apb(1'b1, ADDR_CTRL_ONE, 32'h42);
    `CHK("ebs_zero", 16'h0000, erase_enable)
    summarize();
  end
endmodule
